// >>> rtl/scg_defs.vh
// Constants for the system clock prescaler and sleep gating block
`ifndef SCG_DEFS_VH
`define SCG_DEFS_VH

////////////////////////////////////////////////////////////////////////////
// Register byte offsets on the Avalon-MM slave
`define SCG_OFS_TRIM 4'h0
`define SCG_OFS_DIV 4'h4
`define SCG_OFS_MCU 4'h8
`define SCG_OFS_STAT 4'hC

////////////////////////////////////////////////////////////////////////////
// Field positions and values
`define SCG_DIV_UNLOCK_BIT 7
`define SCG_DIV_UNLOCK_VAL 8'h80
`define SCG_MCU_SM1_BIT 6
`define SCG_MCU_SE_BIT 5
`define SCG_MCU_SM0_BIT 4
`define SCG_SM_IDLE 2'h0
`define SCG_SM_STBY 2'h2

////////////////////////////////////////////////////////////////////////////
// Select codes, select limit and reset values
`define SCG_SEL_DIV1 4'h0
`define SCG_SEL_DIV8 4'h3
`define SCG_SEL_MAX 4'h8
`define SCG_TRIM_RST 7'h00

////////////////////////////////////////////////////////////////////////////
// Timing counts: unlock in system ticks, halt and wake in clk cycles
`define SCG_UNLOCK_CYC 3'h4
`define SCG_HALT_CYC 4'h4
`define SCG_PD_WAKE_CYC 4'hA
`define SCG_STBY_WAKE_CYC 4'h6

`endif

// >>> rtl/scg_prescale.v
// Glitch-free power-of-two prescaler producing the system tick
`timescale 1ns/1ns
`default_nettype none
`include "scg_defs.vh"

module scg_prescale (
	input wire clk,
	input wire rst_n,
	input wire run_en,
	input wire [3:0] div_sel,
	output reg sys_tick_ff,
	output reg clk_level_ff,
	output reg [3:0] cur_sel_ff
);

	reg [7:0] cnt_ff;
	reg [7:0] nxt_cnt;
	reg [3:0] nxt_sel;
	reg nxt_level;
	wire [8:0] period;
	wire at_end;

	// Reserved codes above 8 run at the slowest rate
	function [8:0] div_period;
		input [3:0] sel;
		begin
			if (sel > `SCG_SEL_MAX)
				div_period = 9'h100;
			else
				div_period = 9'h001 << sel;
		end
	endfunction

	assign period = div_period(cur_sel_ff);
	assign at_end = (cnt_ff == period[7:0] - 8'h01) ||
		(period == 9'h100 && cnt_ff == 8'hFF);

	////////////////////////////////////////////////////////////////////////
	// Switch only at a period boundary, so no runt period appears
	always @* begin
		nxt_cnt = cnt_ff;
		nxt_sel = cur_sel_ff;
		nxt_level = clk_level_ff;
		if (run_en) begin
			if (at_end) begin
				nxt_cnt = 8'h00;
				nxt_sel = div_sel;
			end else begin
				nxt_cnt = cnt_ff + 8'h01;
			end
			if (div_period(nxt_sel) == 9'h001)
				nxt_level = ~clk_level_ff;
			else
				nxt_level = ({1'b0, nxt_cnt} < (div_period(nxt_sel) >> 1));
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff <= 8'h00;
			cur_sel_ff <= `SCG_SEL_DIV1;
			sys_tick_ff <= 1'b0;
			clk_level_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			cur_sel_ff <= nxt_sel;
			sys_tick_ff <= run_en & at_end;
			clk_level_ff <= nxt_level;
		end
	end

endmodule // scg_prescale

`default_nettype wire

// >>> rtl/scg_clock_ctrl.v
// System clock control: prescaler registers, trim, clock out, sleep gating
`timescale 1ns/1ns
`default_nettype none
`include "scg_defs.vh"

module scg_clock_ctrl (
	input wire clk,
	input wire rst_n,
	input wire [3:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	output reg [31:0] avs_readdata,
	output wire avs_waitrequest,
	input wire divide_by_eight_fuse,
	input wire clock_output_fuse,
	input wire [7:0] cal_byte,
	input wire crystal_selected,
	input wire sleep_instr,
	input wire any_irq,
	input wire external_irq_zero_level,
	input wire external_irq_one_level,
	input wire pin_change_irq,
	input wire universal_serial_unit_start,
	input wire watchdog_irq,
	input wire gpio_out,
	input wire gpio_oe,
	output wire clkout_pin_o,
	output wire clkout_pin_oe,
	output wire sys_tick,
	output wire cpu_clk_en,
	output wire flash_clk_en,
	output wire io_clk_en,
	output reg osc_en_ff,
	output reg [6:0] osc_trim_ff,
	output reg core_halted_ff,
	output reg sleeping_ff,
	output reg wake_irq_ff
);

	localparam ST_RUN = 5'b00001;
	localparam ST_IDLE = 5'b00010;
	localparam ST_PDOWN = 5'b00100;
	localparam ST_STBY = 5'b01000;
	localparam ST_WAKE = 5'b10000;

	reg ack_ff;
	reg boot_ff;
	reg [3:0] divide_select_ff;
	reg divide_change_unlock_ff;
	reg [2:0] unlock_cnt_ff;
	reg sleep_allow_bit_ff;
	reg [1:0] sleep_mode_select_ff;
	reg [4:0] st_ff;
	reg [4:0] nxt_st;
	reg [3:0] wake_cnt_ff;
	reg [3:0] nxt_wake_cnt;
	reg nxt_wake_irq;
	reg io_run_ff;
	reg cpu_run_ff;
	reg [31:0] nxt_rdata;
	wire req;
	wire wr_go;
	wire wr_lo;
	wire deep_wake;
	wire tick;
	wire clk_level;
	wire [3:0] cur_sel;
	wire [7:0] wbyte;

	function addr_hit;
		input [3:0] addr;
		input [3:0] ofs;
		begin
			addr_hit = (addr == ofs);
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Avalon slave: one wait cycle, then the answer

	assign req = avs_read | avs_write;
	assign avs_waitrequest = req & ~ack_ff;
	assign wr_go = avs_write & ack_ff;
	assign wr_lo = wr_go & avs_byteenable[0];
	assign wbyte = avs_writedata[7:0];

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= req & ~ack_ff;
		end
	end

	// Read data captured in the wait cycle and held for the answer edge
	always @* begin
		nxt_rdata = 32'h0000_0000;
		if (addr_hit(avs_address, `SCG_OFS_TRIM))
			nxt_rdata = {25'h0000000, osc_trim_ff};
		else if (addr_hit(avs_address, `SCG_OFS_DIV))
			nxt_rdata = {24'h000000, divide_change_unlock_ff, 3'h0,
				divide_select_ff};
		else if (addr_hit(avs_address, `SCG_OFS_MCU))
			nxt_rdata = {25'h0000000, sleep_mode_select_ff[1],
				sleep_allow_bit_ff, sleep_mode_select_ff[0], 4'h0};
		else if (addr_hit(avs_address, `SCG_OFS_STAT))
			nxt_rdata = {24'h000000, cur_sel, 1'b0,
				divide_change_unlock_ff, core_halted_ff, sleeping_ff};
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			avs_readdata <= 32'h0000_0000;
		end else if (avs_read & ~ack_ff) begin
			avs_readdata <= nxt_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Straps and calibration are taken one clock after reset release

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			boot_ff <= 1'b1;
		end else begin
			boot_ff <= 1'b0;
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			osc_trim_ff <= `SCG_TRIM_RST;
		end else if (boot_ff) begin
			osc_trim_ff <= cal_byte[6:0];
		end else if (wr_lo && addr_hit(avs_address, `SCG_OFS_TRIM)) begin
			osc_trim_ff <= wbyte[6:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Timed unlock and division select

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			divide_select_ff <= `SCG_SEL_DIV1;
			divide_change_unlock_ff <= 1'b0;
			unlock_cnt_ff <= 3'h0;
		end else if (boot_ff) begin
			if (divide_by_eight_fuse)
				divide_select_ff <= `SCG_SEL_DIV8;
			else
				divide_select_ff <= `SCG_SEL_DIV1;
		end else if (wr_lo && addr_hit(avs_address, `SCG_OFS_DIV) &&
			wbyte == `SCG_DIV_UNLOCK_VAL && !divide_change_unlock_ff) begin
			divide_change_unlock_ff <= 1'b1;
			unlock_cnt_ff <= `SCG_UNLOCK_CYC;
		end else if (wr_lo && addr_hit(avs_address, `SCG_OFS_DIV) &&
			!wbyte[`SCG_DIV_UNLOCK_BIT] && divide_change_unlock_ff) begin
			divide_select_ff <= wbyte[3:0];
			divide_change_unlock_ff <= 1'b0;
		end else if (divide_change_unlock_ff && tick) begin
			// A repeated unlock write lands here and changes nothing
			if (unlock_cnt_ff == 3'h1)
				divide_change_unlock_ff <= 1'b0;
			unlock_cnt_ff <= unlock_cnt_ff - 3'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sleep control register

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sleep_allow_bit_ff <= 1'b0;
			sleep_mode_select_ff <= `SCG_SM_IDLE;
		end else if (wr_lo && addr_hit(avs_address, `SCG_OFS_MCU)) begin
			sleep_allow_bit_ff <= wbyte[`SCG_MCU_SE_BIT];
			sleep_mode_select_ff <= {wbyte[`SCG_MCU_SM1_BIT],
				wbyte[`SCG_MCU_SM0_BIT]};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sleep state machine

	assign deep_wake = external_irq_zero_level | external_irq_one_level |
		pin_change_irq | universal_serial_unit_start | watchdog_irq;

	always @* begin
		nxt_st = st_ff;
		nxt_wake_cnt = wake_cnt_ff;
		nxt_wake_irq = 1'b0;
		case (st_ff)
			ST_RUN: begin
				if (sleep_instr && sleep_allow_bit_ff) begin
					if (sleep_mode_select_ff == `SCG_SM_IDLE)
						nxt_st = ST_IDLE;
					else if (sleep_mode_select_ff == `SCG_SM_STBY &&
						crystal_selected)
						nxt_st = ST_STBY;
					else
						nxt_st = ST_PDOWN;
				end
			end
			ST_IDLE: begin
				if (any_irq) begin
					nxt_st = ST_WAKE;
					nxt_wake_cnt = `SCG_HALT_CYC;
				end
			end
			ST_PDOWN: begin
				if (deep_wake) begin
					nxt_st = ST_WAKE;
					nxt_wake_cnt = `SCG_PD_WAKE_CYC;
				end
			end
			ST_STBY: begin
				if (deep_wake) begin
					nxt_st = ST_WAKE;
					nxt_wake_cnt = `SCG_STBY_WAKE_CYC;
				end
			end
			ST_WAKE: begin
				if (wake_cnt_ff == 4'h1) begin
					nxt_st = ST_RUN;
					nxt_wake_irq = 1'b1;
				end
				nxt_wake_cnt = wake_cnt_ff - 4'h1;
			end
			default: begin
				nxt_st = ST_RUN;
			end
		endcase
	end

	// Reset from any state lands in run, so the core starts from reset
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= ST_RUN;
			wake_cnt_ff <= 4'h0;
			wake_irq_ff <= 1'b0;
		end else begin
			st_ff <= nxt_st;
			wake_cnt_ff <= nxt_wake_cnt;
			wake_irq_ff <= nxt_wake_irq;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Clock domain gating per state

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			osc_en_ff <= 1'b1;
			io_run_ff <= 1'b1;
			cpu_run_ff <= 1'b1;
			core_halted_ff <= 1'b0;
			sleeping_ff <= 1'b0;
		end else begin
			osc_en_ff <= (nxt_st != ST_PDOWN);
			io_run_ff <= (nxt_st == ST_RUN) || (nxt_st == ST_IDLE) ||
				(nxt_st == ST_WAKE);
			cpu_run_ff <= (nxt_st == ST_RUN);
			core_halted_ff <= (nxt_st != ST_RUN);
			sleeping_ff <= (nxt_st == ST_IDLE) || (nxt_st == ST_PDOWN) ||
				(nxt_st == ST_STBY);
		end
	end

	// Prescaler freezes with the oscillator; wake count uses master clk
	scg_prescale u_prescale (
		.clk(clk),
		.rst_n(rst_n),
		.run_en(osc_en_ff),
		.div_sel(divide_select_ff),
		.sys_tick_ff(tick),
		.clk_level_ff(clk_level),
		.cur_sel_ff(cur_sel)
	);

	assign sys_tick = tick;
	assign cpu_clk_en = tick & cpu_run_ff;
	assign flash_clk_en = tick & cpu_run_ff;
	assign io_clk_en = tick & io_run_ff;

	////////////////////////////////////////////////////////////////////////
	// Clock output pin overrides the port function

	assign clkout_pin_o = clock_output_fuse ? clk_level : gpio_out;
	assign clkout_pin_oe = clock_output_fuse ? 1'b1 : gpio_oe;

endmodule // scg_clock_ctrl

`default_nettype wire

// >>> verification/scg_props.sv
// Assertion checker for the clock control block
`timescale 1ns/1ns
`default_nettype none

module scg_props (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sleep_instr,
	input wire logic clock_output_fuse,
	input wire logic gpio_out,
	input wire logic clkout_pin_o,
	input wire logic clkout_pin_oe,
	input wire logic sys_tick,
	input wire logic cpu_clk_en,
	input wire logic flash_clk_en,
	input wire logic io_clk_en,
	input wire logic osc_en_ff,
	input wire logic core_halted_ff,
	input wire logic sleeping_ff,
	input wire logic wake_irq_ff
);
default clocking @(posedge clk); endclocking
default disable iff (!rst_n);
////////////////////////////////////////////////////////////////////////////
a_pin_fuse_owns: assert property (
	(clock_output_fuse |-> clkout_pin_oe) and
	(!clock_output_fuse |-> clkout_pin_o == gpio_out)) else $error("pin mux");
// Own disable: this one must hold while reset is low
a_pin_reset_still: assert property (disable iff (1'b0)
	!rst_n && clock_output_fuse |-> !clkout_pin_o) else $error("pin moved");
a_cpu_gated: assert property (
	sleeping_ff |-> !cpu_clk_en && !flash_clk_en) else $error("cpu clock");
a_osc_stop_sleep: assert property (
	!osc_en_ff |-> sleeping_ff) else $error("osc off in run");
a_tick_feeds_all: assert property (
	cpu_clk_en |-> sys_tick && flash_clk_en && io_clk_en) else $error("feed");
a_wake_pulse_end: assert property (
	wake_irq_ff |-> $past(core_halted_ff) && !core_halted_ff && !sleeping_ff)
	else $error("wake pulse");
a_sleep_cause: assert property (
	$rose(sleeping_ff) |-> $past(sleep_instr)) else $error("sleep cause");
a_halt_four: assert property (
	$fell(sleeping_ff) |-> core_halted_ff[*4]) else $error("halt short");
a_halt_in_sleep: assert property (
	sleeping_ff |-> core_halted_ff) else $error("halt in sleep");
c_deep: cover property ($rose(sleeping_ff) ##1 !osc_en_ff);
c_wake: cover property (wake_irq_ff);
c_idle: cover property (sleeping_ff && io_clk_en);
endmodule // scg_props

bind scg_clock_ctrl scg_props u_props (.clk, .rst_n, .sleep_instr,
	.clock_output_fuse, .gpio_out, .clkout_pin_o, .clkout_pin_oe, .sys_tick,
	.cpu_clk_en, .flash_clk_en, .io_clk_en, .osc_en_ff, .core_halted_ff,
	.sleeping_ff, .wake_irq_ff);
`default_nettype wire

// >>> verification/tb.sv
// Self-checking bench for the clock control block
`timescale 1ns/1ns
`default_nettype none

module tb;
logic clk = 1'b0;
logic rst_n = 1'b0;
logic [3:0] avs_address = 4'h0;
logic avs_read = 1'b0;
logic avs_write = 1'b0;
logic [31:0] avs_writedata = 32'h0;
logic [3:0] avs_byteenable = 4'hF;
logic divide_by_eight_fuse = 1'b1;
logic clock_output_fuse = 1'b1;
logic [7:0] cal_byte = 8'h00;
logic crystal_selected = 1'b0;
logic sleep_instr = 1'b0;
logic any_irq = 1'b0;
logic gpio_out = 1'b0;
logic gpio_oe = 1'b0;
logic [4:0] wk = 5'h00;
logic [7:0] d;
logic [31:0] q;
int err_count = 0;
int checks_done = 0;
int seed = 27549;
int n, h, s;
wire external_irq_zero_level, external_irq_one_level, pin_change_irq;
wire universal_serial_unit_start, watchdog_irq;
wire [31:0] avs_readdata;
wire avs_waitrequest, clkout_pin_o, clkout_pin_oe, sys_tick, cpu_clk_en;
wire flash_clk_en, io_clk_en, osc_en_ff, core_halted_ff, sleeping_ff;
wire wake_irq_ff;
wire [6:0] osc_trim_ff;
assign {watchdog_irq, universal_serial_unit_start, pin_change_irq,
	external_irq_one_level, external_irq_zero_level} = wk;

scg_clock_ctrl dut (.clk, .rst_n, .avs_address, .avs_read, .avs_write,
	.avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
	.divide_by_eight_fuse, .clock_output_fuse, .cal_byte, .crystal_selected,
	.sleep_instr, .any_irq, .external_irq_zero_level, .external_irq_one_level,
	.pin_change_irq, .universal_serial_unit_start, .watchdog_irq, .gpio_out,
	.gpio_oe, .clkout_pin_o, .clkout_pin_oe, .sys_tick, .cpu_clk_en,
	.flash_clk_en, .io_clk_en, .osc_en_ff, .osc_trim_ff, .core_halted_ff,
	.sleeping_ff, .wake_irq_ff);

always #20 clk = ~clk;
////////////////////////////////////////////////////////////////////////////
task conclude;
	if (err_count == 0 && checks_done > 0)
		$display("Simulation passed");
	else
		$display("Simulation failed");
	$finish;
endtask

task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
	checks_done++;
	if (seen !== exp) begin
		err_count++;
		$display("Error %s expected %h seen %h", nm, exp, seen);
	end
endtask

// Holds the request until waitrequest is sampled low at an edge
task bus(input logic w, input logic [3:0] a, input logic [7:0] v);
	@(posedge clk);
	avs_address <= a;
	avs_write <= w;
	avs_read <= !w;
	avs_writedata <= {24'h0, v};
	// No local limit: only the watchdog ends a hung request
	do begin
		@(posedge clk);
	end while (avs_waitrequest !== 1'b0);
	q = avs_readdata;
	avs_read <= 1'b0;
	avs_write <= 1'b0;
endtask

// Period between two ticks, and pin high cycles within it
task meas(output int p, output int hi);
	p = 0;
	hi = 0;
	do @(posedge clk); while (sys_tick !== 1'b1 && ++p < 600);
	p = 0;
	do begin
		@(posedge clk);
		p++;
		hi += clkout_pin_o;
	end while (sys_tick !== 1'b1 && p < 600);
endtask

task setdiv(input int c);
	bus(1'b1, 4'h4, 8'h80);
	bus(1'b1, 4'h4, {4'h7, c[3:0]});
	// Skip a tick launched on the write edge under the old select
	@(posedge clk);
	meas(n, h);
	chk("first period", n, 1 << c);
	meas(n, h);
	chk("period", n, 1 << c);
	if (c > 0) chk("pin high", h, 1 << (c - 1));
	bus(1'b0, 4'h4, 8'h00);
	chk("div reg", q, c);
	bus(1'b0, 4'hC, 8'h00);
	chk("status", q, c << 4);
endtask

// hw: halted cycles on wake, 0 refused, -1 reset while asleep
task slp(input logic [7:0] m, input int src, input int hw);
	bus(1'b1, 4'h8, m);
	bus(1'b0, 4'h8, 8'h00);
	chk("mcu reg", q, m & 8'h70);
	@(posedge clk) sleep_instr <= 1'b1;
	@(posedge clk) sleep_instr <= 1'b0;
	@(posedge clk);
	chk("sleeping", sleeping_ff, hw != 0);
	if (hw < 0) begin
		rst_n <= 1'b0;
		@(posedge clk);
		chk("reset wake", {sleeping_ff, core_halted_ff}, 0);
		rst_n <= 1'b1;
	end else if (hw > 0) begin
		chk("cpu clk", cpu_clk_en | flash_clk_en, 0);
		chk("osc", osc_en_ff, hw != 10);
		chk("io clk", io_clk_en, hw == 4 ? sys_tick : 1'b0);
		any_irq <= 1'b1;
		if (hw != 4) begin
			repeat (3) @(posedge clk);
			chk("deep ignores irq", sleeping_ff, 1);
			wk <= 5'h01 << src;
		end
		n = 0;
		while (sleeping_ff === 1'b1 && n < 20) begin
			@(posedge clk);
			n++;
		end
		n = 0;
		while (core_halted_ff === 1'b1 && n < 40) begin
			@(posedge clk);
			n++;
		end
		chk("halt cycles", n, hw);
		chk("wake pulse", wake_irq_ff, 1);
		any_irq <= 1'b0;
		wk <= 5'h00;
	end
endtask
////////////////////////////////////////////////////////////////////////////
initial begin
	repeat (40000) @(posedge clk);
	err_count++;
	conclude;
end

initial begin
	cal_byte <= $random(seed);
	repeat (16) @(posedge clk);
	rst_n <= 1'b1;
	repeat (2) @(posedge clk);
	bus(1'b0, 4'h0, 8'h00);
	chk("boot trim", q, cal_byte[6:0]);
	bus(1'b0, 4'h4, 8'h00);
	chk("boot div", q, 3);
	bus(1'b1, 4'h4, 8'h81);
	bus(1'b1, 4'h4, 8'h02);
	bus(1'b0, 4'h4, 8'h00);
	chk("no unlock", q, 3);
	bus(1'b1, 4'h4, 8'h80);
	bus(1'b0, 4'h4, 8'h00);
	chk("unlocked", q, 8'h83);
	bus(1'b1, 4'h4, 8'h80);
	bus(1'b1, 4'h4, 8'h04);
	bus(1'b0, 4'h4, 8'h00);
	chk("rewrite unlock", q, 4);
	bus(1'b1, 4'h4, 8'h80);
	repeat (3) meas(n, h);
	bus(1'b1, 4'h4, 8'h02);
	bus(1'b0, 4'h4, 8'h00);
	chk("unlock expired", q, 4);
	// Two ticks, rewrite, two more: a restart would still be open
	bus(1'b1, 4'h4, 8'h80);
	meas(n, h);
	bus(1'b1, 4'h4, 8'h80);
	meas(n, h);
	bus(1'b1, 4'h4, 8'h02);
	bus(1'b0, 4'h4, 8'h00);
	chk("no restart", q, 4);
	bus(1'b1, 4'h4, 8'h80);
	bus(1'b1, 4'h4, 8'h0B);
	@(posedge clk);
	repeat (2) meas(n, h);
	chk("reserved period", n, 256);
	bus(1'b0, 4'h4, 8'h00);
	chk("reserved sel", q, 8'h0B);
	for (s = 8; s >= 0; s--) setdiv(s);
	d = $random(seed);
	// Step stays under 0x20 from the boot value
	d = {1'b1, cal_byte[6:0] ^ {2'b00, d[4:0]}};
	bus(1'b1, 4'h0, d);
	bus(1'b0, 4'h0, 8'h00);
	chk("trim reg", q, d[6:0]);
	chk("trim out", osc_trim_ff, d[6:0]);
	avs_byteenable <= 4'hE;
	bus(1'b1, 4'h0, ~d);
	avs_byteenable <= 4'hF;
	bus(1'b0, 4'h0, 8'h00);
	chk("masked write", q, d[6:0]);
	bus(1'b0, 4'h2, 8'h00);
	chk("unmapped", q, 0);
	clock_output_fuse <= 1'b0;
	gpio_out <= $random(seed);
	gpio_oe <= 1'b1;
	@(posedge clk);
	chk("gpio pin", {clkout_pin_oe, clkout_pin_o}, {1'b1, gpio_out});
	clock_output_fuse <= 1'b1;
	slp(8'h00, 0, 0);
	slp(8'h20, 0, 4);
	slp(8'h30, $unsigned($random(seed)) % 5, 10);
	slp(8'h70, $unsigned($random(seed)) % 5, 10);
	slp(8'h60, $unsigned($random(seed)) % 5, 10);
	crystal_selected <= 1'b1;
	slp(8'h60, $unsigned($random(seed)) % 5, 6);
	divide_by_eight_fuse <= $random(seed);
	cal_byte <= $random(seed);
	slp(8'h30, 0, -1);
	repeat (2) @(posedge clk);
	bus(1'b0, 4'h4, 8'h00);
	chk("div after reset", q, divide_by_eight_fuse ? 3 : 0);
	bus(1'b0, 4'h0, 8'h00);
	chk("trim after reset", q, cal_byte[6:0]);
	conclude;
end
endmodule // tb
`default_nettype wire
